//--- board_straps.sv
module board_straps (
  input  wire logic                   sys_clk_i,
  input  wire logic                   osc_run_i,
  input  wire clock_boot_pkg::strap_t strap_i,
  output logic [1:0]                  clock_boot_select_o,
  output logic                        crystal_lvl_o,
  output logic                        reset_config_pin_n_o,
  output logic                        test_pin_o,
  output logic                        ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ext_clk_q;

  assign clock_boot_select_o  = strap_i.sel;
  assign crystal_lvl_o        = strap_i.crystal;
  assign reset_config_pin_n_o = strap_i.cfg_pin_n;
  assign test_pin_o           = strap_i.test;
  assign ext_clk_o            = ext_clk_q;

  // parked oscillator sits opposite the strap, so a driven pad reads it back
  always_ff @(negedge sys_clk_i) begin
    if (osc_run_i) begin
      ext_clk_q <= ~ext_clk_q;
    end else begin
      ext_clk_q <= ~strap_i.crystal;
    end
  end
endmodule

//--- clock_boot_mode_select.sv
module clock_boot_mode_select #(
  parameter int unsigned HOLD_CYCLES = clock_boot_pkg::RESET_HOLD_CLKS,
  parameter int unsigned CLK_DIV     = clock_boot_pkg::OUT_DIV
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [1:0]               clock_boot_select_i,
  input  wire logic                     crystal_pin_i,
  output logic                          crystal_pin_o,
  output logic                          crystal_pin_oe_o,
  input  wire logic                     ext_clock_in_i,
  input  wire logic                     reset_config_pin_n_i,
  input  wire logic                     test_pin_i,
  output logic                          reset_out_pin_n_o,
  output logic                          pll_enable_o,
  output clock_boot_pkg::clk_src_t      ref_source_o,
  output logic                          ext_clock_in_enable_o,
  output logic                          system_clock_out_o,
  output logic                          flash_prog_mode_o,
  output logic                          flash_port_grant_o,
  output logic                          cfg_valid_o
);

  localparam int unsigned DW = clock_boot_pkg::OUT_DIV_W;
  localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);

  //////////////////////////////////////////////////////////////////////////
  // strap decode

  function automatic clock_boot_pkg::boot_cfg_t decode(
    input clock_boot_pkg::strap_t s
  );
    clock_boot_pkg::boot_cfg_t c;
    c.pll_en = s.sel[clock_boot_pkg::SEL_PLL_BIT];
    case (s.sel)
      2'h0: begin
        c.src = s.crystal ? clock_boot_pkg::SRC_RELAX_OSC
                       : clock_boot_pkg::SRC_EXT_OSC;
      end
      2'h1: begin
        c.src = clock_boot_pkg::SRC_CRYSTAL;
      end
      2'h2: begin
        c.src = s.crystal ? clock_boot_pkg::SRC_RELAX_OSC
                       : clock_boot_pkg::SRC_EXT_OSC;
      end
      2'h3: begin
        c.src = clock_boot_pkg::SRC_CRYSTAL;
      end
      default: begin
        c.src = clock_boot_pkg::SRC_EXT_OSC;
      end
    endcase
    c.flash_prog = !s.cfg_pin_n && !s.test;
    return c;
  endfunction

  clock_boot_pkg::strap_t straps;
  assign straps = '{
    sel:       clock_boot_select_i,
    crystal:   crystal_pin_i,
    cfg_pin_n: reset_config_pin_n_i,
    test:      test_pin_i
  };

  //////////////////////////////////////////////////////////////////////////
  // reset hold window

  logic reset_out_n;
  logic release_now;

  reset_stretch #(
    .HOLD_CYCLES (HOLD_CYCLES),
    .CNT_W       (clock_boot_pkg::RESET_CNT_W)
  ) u_reset_stretch (
    .sys_clk_i     (sys_clk_i),
    .rst_n_i       (rst_n_i),
    .reset_out_n_o (reset_out_n),
    .release_o     (release_now)
  );

  assign reset_out_pin_n_o = reset_out_n;

  //////////////////////////////////////////////////////////////////////////
  // boot mode state

  clock_boot_pkg::boot_state_t state_q;
  clock_boot_pkg::boot_state_t state_d;
  clock_boot_pkg::boot_cfg_t   cfg_q;
  clock_boot_pkg::boot_cfg_t   cfg_d;
  logic                        ext_en_q;
  logic                        ext_en_d;

  always_comb begin
    state_d  = state_q;
    cfg_d    = cfg_q;
    ext_en_d = ext_en_q;
    case (state_q)
      clock_boot_pkg::ST_HOLD: begin
        if (release_now) begin
          cfg_d    = decode(straps);
          ext_en_d = (cfg_d.src
                      != clock_boot_pkg::SRC_RELAX_OSC);
          state_d  = clock_boot_pkg::ST_RUN;
        end
      end
      clock_boot_pkg::ST_RUN: begin
        state_d = clock_boot_pkg::ST_RUN;
      end
      default: begin
        state_d = clock_boot_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q  <= clock_boot_pkg::ST_HOLD;
      cfg_q    <= clock_boot_pkg::CFG_RESET;
      ext_en_q <= 1'h1;
    end else begin
      state_q  <= state_d;
      cfg_q    <= cfg_d;
      ext_en_q <= ext_en_d;
    end
  end

  assign pll_enable_o          = cfg_q.pll_en;
  assign ref_source_o          = cfg_q.src;
  assign flash_prog_mode_o     = cfg_q.flash_prog;
  assign flash_port_grant_o    = cfg_q.flash_prog;
  assign ext_clock_in_enable_o = ext_en_q;
  assign cfg_valid_o           = (state_q == clock_boot_pkg::ST_RUN);

  //////////////////////////////////////////////////////////////////////////
  // crystal pin driver and clock out

  logic          pad_o_q;
  logic          pad_o_d;
  logic          pad_oe_q;
  logic          pad_oe_d;
  logic [DW-1:0] div_q;
  logic [DW-1:0] div_d;
  logic          sysclk_out_q;
  logic          sysclk_out_d;
  logic          upper_sel;
  logic          tick;

  // before the latch the live pin decides whether the pad is driven
  assign upper_sel = cfg_valid_o
                     ? cfg_q.pll_en
                     : clock_boot_select_i[clock_boot_pkg::SEL_PLL_BIT];
  assign tick = (div_q == DIV_LAST);

  always_comb begin
    pad_oe_d     = !upper_sel;
    pad_o_d      = !ext_clock_in_i;
    div_d        = div_q;
    sysclk_out_d = sysclk_out_q;
    if (cfg_valid_o) begin
      div_d = tick ? '0 : div_q + 1'h1;
      if (tick) begin
        sysclk_out_d = !sysclk_out_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pad_o_q      <= 1'h0;
      pad_oe_q     <= 1'h0;
      div_q        <= '0;
      sysclk_out_q <= 1'h0;
    end else begin
      pad_o_q      <= pad_o_d;
      pad_oe_q     <= pad_oe_d;
      div_q        <= div_d;
      sysclk_out_q <= sysclk_out_d;
    end
  end

  assign crystal_pin_o      = pad_o_q;
  assign crystal_pin_oe_o   = pad_oe_q;
  assign system_clock_out_o = sysclk_out_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [11:0] low_cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      low_cnt_q <= '0;
    end else if (!reset_out_n) begin
      low_cnt_q <= low_cnt_q + 1'h1;
    end
  end

  a_reset_hold_len: assert property (
    $rose(reset_out_pin_n_o) |-> low_cnt_q == 12'(HOLD_CYCLES))
    else $error("reset out hold length wrong");

  a_pll_from_sel: assert property (
    release_now |=> pll_enable_o == $past(clock_boot_select_i[1]))
    else $error("pll enable does not follow select");

  a_src_crystal: assert property (
    release_now && clock_boot_select_i[0]
    |=> ref_source_o == clock_boot_pkg::SRC_CRYSTAL)
    else $error("crystal mode source wrong");

  a_src_sampled: assert property (
    release_now && !clock_boot_select_i[0] && crystal_pin_i
    |=> ref_source_o == clock_boot_pkg::SRC_RELAX_OSC ##0 cfg_valid_o)
    else $error("sampled source wrong");

  a_flash_entry: assert property (
    release_now |=> flash_prog_mode_o
                    == (!$past(reset_config_pin_n_i) && !$past(test_pin_i)))
    else $error("flash programming entry wrong");

  a_flash_grant: assert property (
    release_now |=> flash_port_grant_o
                    == (!$past(reset_config_pin_n_i) && !$past(test_pin_i)))
    else $error("flash port grant mismatch");

  a_cfg_stable: assert property (
    cfg_valid_o |=> $stable(cfg_q) && cfg_valid_o)
    else $error("latched mode changed");

  a_crystal_pin_oe: assert property (
    cfg_valid_o [*2] |-> crystal_pin_oe_o == !pll_enable_o)
    else $error("crystal pin drive wrong");

  a_ext_in_use: assert property (
    cfg_valid_o |-> ext_clock_in_enable_o
                    == (ref_source_o != clock_boot_pkg::SRC_RELAX_OSC))
    else $error("external clock input use wrong");

  a_system_clock_out_toggle: assert property (
    cfg_valid_o && tick |=> system_clock_out_o != $past(system_clock_out_o))
    else $error("clock out did not toggle");

endmodule

//--- clock_boot_mode_select_tb.sv
module clock_boot_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     sys_clk = 1'b0;
  logic                     rst_n   = 1'b0;
  logic                     osc_run = 1'b0;
  clock_boot_pkg::strap_t   strap   = '0;
  logic [1:0]               sel;
  logic                     xt_lvl, cfg_n, test, ext_clk, xt_o, xt_oe, pad;
  logic                     rst_out_n, pll, ext_en, clk_out, flash, grant;
  logic                     valid;
  clock_boot_pkg::clk_src_t src;
  int                       error_cnt = 0;
  int                       num_checks = 0;

  always #2.5 sys_clk = ~sys_clk;
  assign pad = xt_oe ? xt_o : xt_lvl;

  board_straps brd_u (
    .sys_clk_i(sys_clk), .osc_run_i(osc_run), .strap_i(strap),
    .clock_boot_select_o(sel), .crystal_lvl_o(xt_lvl),
    .reset_config_pin_n_o(cfg_n), .test_pin_o(test), .ext_clk_o(ext_clk)
  );

  clock_boot_mode_select #(.HOLD_CYCLES(8), .CLK_DIV(1)) dut_u (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .clock_boot_select_i(sel),
    .crystal_pin_i(pad), .crystal_pin_o(xt_o), .crystal_pin_oe_o(xt_oe),
    .ext_clock_in_i(ext_clk), .reset_config_pin_n_i(cfg_n),
    .test_pin_i(test), .reset_out_pin_n_o(rst_out_n),
    .pll_enable_o(pll), .ref_source_o(src), .ext_clock_in_enable_o(ext_en),
    .system_clock_out_o(clk_out), .flash_prog_mode_o(flash),
    .flash_port_grant_o(grant), .cfg_valid_o(valid)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one boot: strap, reset, latch, then disturb straps and check hold
  task automatic boot(input logic [1:0] s, input logic x, r, t);
    int                       n;
    logic                     v;
    logic                     fl;
    clock_boot_pkg::clk_src_t es;
    @(negedge sys_clk);
    rst_n   = 1'b0;
    osc_run = 1'b0;
    strap   = '{sel: s, crystal: x, cfg_pin_n: r, test: t};
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rst_out_n !== 1'b1 && n < 100);
    check(8'(n), 8'h08);
    es = s[0] ? clock_boot_pkg::SRC_CRYSTAL :
         (x ? clock_boot_pkg::SRC_RELAX_OSC : clock_boot_pkg::SRC_EXT_OSC);
    fl = !r && !t;
    check(8'(pll), 8'(s[1]));
    check(8'(src), 8'(es));
    check(8'(ext_en), 8'(es != clock_boot_pkg::SRC_RELAX_OSC));
    check(8'(flash), 8'(fl));
    check(8'(grant), 8'(fl));
    check(8'(valid), 8'h01);
    @(negedge sys_clk);
    strap   = '{sel: ~s, crystal: ~x, cfg_pin_n: ~r, test: 1'b0};
    osc_run = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(8'({pll, src, flash}), 8'({s[1], es, fl}));
    check(8'(xt_oe), 8'(!s[1]));
    @(posedge sys_clk);
    #1;
    v = clk_out;
    if (xt_oe === 1'b1) begin
      check(8'(xt_o), 8'(!ext_clk));
    end
    @(posedge sys_clk);
    #1;
    check(8'(clk_out), 8'(!v));
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      boot(2'(i >> 1), i[0], 1'b1, 1'b0);
    end
    boot(2'h0, 1'b0, 1'b0, 1'b0);
    boot(2'h1, 1'b1, 1'b0, 1'b1);
    boot(2'h3, 1'b0, 1'b1, 1'b1);
    summarize();
  end
endmodule

//--- clock_boot_pkg.sv
package clock_boot_pkg;

  localparam int unsigned SYS_CLK_HZ      = 200_000_000;
  localparam int unsigned RESET_HOLD_CLKS = 1024;
  localparam int unsigned RESET_CNT_W     = 11;
  localparam int unsigned OUT_DIV         = 1;
  localparam int unsigned OUT_DIV_W       = 4;
  localparam int unsigned SEL_PLL_BIT     = 1;
  localparam int unsigned SEL_SRC_BIT     = 0;

  typedef enum logic [1:0] {
    SRC_EXT_OSC   = 2'h0,
    SRC_RELAX_OSC = 2'h1,
    SRC_CRYSTAL   = 2'h2
  } clk_src_t;

  typedef enum logic [0:0] {
    ST_HOLD = 1'h0,
    ST_RUN  = 1'h1
  } boot_state_t;

  typedef struct packed {
    logic     pll_en;
    clk_src_t src;
    logic     flash_prog;
  } boot_cfg_t;

  typedef struct packed {
    logic [1:0] sel;
    logic       crystal;
    logic       cfg_pin_n;
    logic       test;
  } strap_t;

  localparam boot_cfg_t CFG_RESET = '{
    pll_en:     1'h0,
    src:        SRC_EXT_OSC,
    flash_prog: 1'h0
  };

endpackage

//--- reset_stretch.sv
module reset_stretch #(
  parameter int unsigned HOLD_CYCLES = clock_boot_pkg::RESET_HOLD_CLKS,
  parameter int unsigned CNT_W       = clock_boot_pkg::RESET_CNT_W
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  output logic      reset_out_n_o,
  output logic      release_o
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             done_q;
  logic             done_d;

  // count the hold window once the reset source has let go
  always_comb begin
    count_d = count_q;
    done_d  = done_q;
    if (!done_q) begin
      if (count_q == LAST) begin
        done_d = 1'h1;
      end else begin
        count_d = count_q + 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      done_q  <= 1'h0;
    end else begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

  assign reset_out_n_o = done_q;
  assign release_o     = !done_q && (count_q == LAST);

endmodule
